// ===== common/pfl_pkg.sv
// Shared constants and types of the programmable function line block.
// Assumes one 50 MHz system clock and a classic Wishbone register bus.
package pfl_pkg;

    // =====================================================================
    // Sizes
    localparam int unsigned NUM_LINES = 8;
    localparam int unsigned NUM_DEST = 24;

    // =====================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATIC_OUT = 8'h04;
    localparam logic [7:0] OFS_STATIC_IN = 8'h08;
    localparam logic [7:0] OFS_DRIVE = 8'h0C;
    localparam logic [7:0] OFS_FILTER = 8'h10;
    localparam logic [7:0] OFS_ROUTE0 = 8'h14;
    localparam logic [7:0] OFS_ROUTE1 = 8'h18;
    localparam logic [7:0] OFS_ROUTE2 = 8'h1C;
    localparam logic [7:0] OFS_DEST_POL = 8'h20;
    localparam logic [7:0] OFS_DEST_EDGE = 8'h24;
    localparam logic [7:0] OFS_EXPORT = 8'h28;
    localparam logic [7:0] OFS_TBUS_ROUTE = 8'h2C;

    // Reset value of every register; all lines idle and undriven
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Field positions
    localparam int unsigned MODE_OUT_LSB = 8;
    localparam int unsigned NIB_EN_BIT = 3;

    // =====================================================================
    // Timing
    localparam logic [6:0] FILT_CLK_MHZ = 7'h28;   // 40 MHz filter clock
    localparam logic [6:0] SYS_CLK_MHZ = 7'h32;    // 50 MHz system clock
    localparam int unsigned SYS_CLK_PERIOD_NS = 32'h0000_0014;
    localparam int unsigned JITTER_NS = 32'h0000_0019;   // 25 ns
    localparam int unsigned TICK_GAP_LIMIT = JITTER_NS / SYS_CLK_PERIOD_NS;
    localparam logic [16:0] FLT_N_SHORT = 17'h0_0005;    // 5 samples
    localparam logic [16:0] FLT_N_MID = 17'h0_0101;      // 257 samples
    localparam int FLT_N_LONG_DEF = 32'h0001_8DA8;       // 101800 samples

    // =====================================================================
    // Enumerations
    typedef enum logic [1:0] {
        FLT_OFF, FLT_125NS, FLT_6425NS, FLT_2550US
    } pfl_filt_e;

    typedef enum logic [1:0] {
        DRV_HIZ, DRV_LOW, DRV_HIGH, DRV_ACTIVE
    } pfl_drive_e;

    typedef enum logic [3:0] {
        SRC_AI_CONVERT, SRC_AI_HOLD_DONE, SRC_AI_REFERENCE, SRC_AI_SAMPLE,
        SRC_AI_START, SRC_AO_SAMPLE, SRC_AO_START, SRC_CTR0_SOURCE,
        SRC_CTR1_SOURCE, SRC_CTR0_GATE, SRC_CTR1_GATE, SRC_CTR0_OUT,
        SRC_CTR1_OUT, SRC_FREQ_OUT, SRC_TBUS
    } pfl_src_e;

    // =====================================================================
    // Carriers
    typedef struct packed {
        logic ai_convert;
        logic ai_sample;
        logic ai_start;
        logic ai_reference;
        logic ai_pause;
        logic ai_timebase;
        logic ao_start;
        logic ao_sample;
        logic ao_timebase;
        logic ao_pause;
        logic [1:0] ctr_source;
        logic [1:0] ctr_gate;
        logic [1:0] ctr_aux;
        logic [1:0] counter_arm_input;
        logic [1:0] ctr_a;
        logic [1:0] ctr_b;
        logic [1:0] ctr_z;
    } pfl_dest_s;

    typedef struct packed {
        logic ai_convert;
        logic ai_hold_done;
        logic ai_reference;
        logic ai_sample;
        logic ai_start;
        logic ao_sample;
        logic ao_start;
        logic [1:0] ctr_source;
        logic [1:0] ctr_gate;
        logic [1:0] ctr_out;
        logic freq_out;
    } pfl_src_s;

    typedef struct packed {
        logic [15:0] mode;
        logic [7:0] static_out;
        logic [15:0] drive;
        logic [15:0] filter;
        logic [95:0] route;
        logic [23:0] dest_pol;
        logic [23:0] dest_edge;
        logic [31:0] export_sel;
        logic [31:0] tbus_route;
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
        logic [7:0] tb_meta;
        logic [7:0] tb_sync;
        logic [6:0] phase;
        logic tick;
        logic [23:0] dest;
        logic [23:0] dest_prev;
        logic [7:0] line_out;
        logic [7:0] line_oe;
        logic [7:0] tbus_out;
        logic [7:0] tbus_oe;
        logic ack;
        logic [31:0] rdata;
    } pfl_state_s;

    typedef struct packed {
        logic level;
        logic [16:0] cnt;
    } pfl_filt_state_s;

endpackage

// ===== core/pfl_filter.sv
// Debouncing filter for one programmable function line.
// Assumes a synchronised sample and a filter-clock tick from the parent.
`timescale 1ns/1ps
module pfl_filter
    import pfl_pkg::*;
#(
    parameter int LONG_N = FLT_N_LONG_DEF
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic sample_i,
    input wire pfl_filt_e setting_i,
    output logic level_o
);

    // =====================================================================
    // State
    pfl_filt_state_s s_reg;
    pfl_filt_state_s s_next;
    logic [16:0] need;

    // Count consecutive differing samples; a match restarts the count
    always_comb
    begin
        s_next = s_reg;
        need = FLT_N_SHORT;
        unique case (setting_i)
            FLT_OFF: need = FLT_N_SHORT;
            FLT_125NS: need = FLT_N_SHORT;
            FLT_6425NS: need = FLT_N_MID;
            FLT_2550US: need = LONG_N[16:0];
        endcase
        if (setting_i == FLT_OFF)
        begin
            // Bypass follows the pin every clock, not only on ticks
            s_next.level = sample_i;
            s_next.cnt = '0;
        end
        else if (tick_i)
        begin
            if (sample_i == s_reg.level)
            begin
                s_next.cnt = '0;
            end
            else if (s_reg.cnt == need - 17'h0_0001)
            begin
                s_next.level = sample_i;
                s_next.cnt = '0;
            end
            else
            begin
                s_next.cnt = s_reg.cnt + 17'h0_0001;
            end
        end
    end

    // Register the state; level starts low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_next_unused_guard: s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.level;

    // =====================================================================
    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_glitch_restart: assert property (
        (setting_i != FLT_OFF && tick_i && sample_i == s_reg.level)
        |=> s_reg.cnt == 17'h0_0000)
        else $error("filter count not restarted on matching sample");

    chk_pass_count: assert property (
        ($changed(s_reg.level) && $past(setting_i) != FLT_OFF)
        |-> $past(s_reg.cnt) == $past(need) - 17'h0_0001)
        else $error("level passed before the required sample count");

    chk_bypass_follow: assert property (
        setting_i == FLT_OFF |=> s_reg.level == $past(sample_i))
        else $error("disabled filter did not pass the sample");

endmodule

// ===== core/pfl_function_io.sv
// Programmable function line routing, export, filtering and drive.
// Assumes classic Wishbone on clk_i (50 MHz), pins synchronised here,
// and internal timing sources on the same clock.
//
// Function
// - Eight input and eight output lines, each configured on its own.
// - Each input is a static input or a routed timing input.
// - Each output is a static output or an exported timing signal.
// - Any input may feed any analog-in, analog-out or counter destination.
// - Routed inputs have selectable polarity and edge or level sense.
// - Any output may export any listed internal timing signal.
// - Exported analog-in convert and analog-out sample clocks are inverted.
// - Enabled filters sample the input at a 40 MHz filter rate.
// - A level passes only after N consecutive equal new samples.
// - N is 5, 257 or about 101800; disabled means no filtering.
// - Filter settings are per line and all disabled after reset.
// - Filter jitter stays within 25 ns for the short settings.
// - Trigger bus routes use the unfiltered line signal.
// - Static input x is bit x of port zero; output x of port one.
// - After reset every output line is undriven.
// - Each line's state is undriven, driving 0 or driving 1.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module pfl_function_io
    import pfl_pkg::*;
#(
    parameter int LONG_N = FLT_N_LONG_DEF
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] line_in_i,
    output logic [7:0] line_out_o,
    output logic [7:0] line_oe_o,
    input wire logic [7:0] tbus_in_i,
    output logic [7:0] tbus_out_o,
    output logic [7:0] tbus_oe_o,
    input wire pfl_src_s src_i,
    output pfl_dest_s dest_o
);

    // =====================================================================
    // State and helpers
    pfl_state_s s_reg;
    pfl_state_s s_next;
    logic [NUM_LINES-1:0] level;

    // Byte-lane merge of a write into the current register value
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Pick one internal timing signal for export; clocks that are
    // active low on the pin are inverted here
    function automatic logic pick(
        input pfl_src_s src,
        input logic tb,
        input logic [3:0] code
    );
        logic r;
        r = 1'b0;
        case (pfl_src_e'(code))
            SRC_AI_CONVERT: r = ~src.ai_convert;
            SRC_AI_HOLD_DONE: r = src.ai_hold_done;
            SRC_AI_REFERENCE: r = src.ai_reference;
            SRC_AI_SAMPLE: r = src.ai_sample;
            SRC_AI_START: r = src.ai_start;
            SRC_AO_SAMPLE: r = ~src.ao_sample;
            SRC_AO_START: r = src.ao_start;
            SRC_CTR0_SOURCE: r = src.ctr_source[0];
            SRC_CTR1_SOURCE: r = src.ctr_source[1];
            SRC_CTR0_GATE: r = src.ctr_gate[0];
            SRC_CTR1_GATE: r = src.ctr_gate[1];
            SRC_CTR0_OUT: r = src.ctr_out[0];
            SRC_CTR1_OUT: r = src.ctr_out[1];
            SRC_FREQ_OUT: r = src.freq_out;
            SRC_TBUS: r = tb;
            default: r = 1'b0;                      // Unused code
        endcase
        return r;
    endfunction

    // =====================================================================
    // Per-line filters
    for (genvar g = 0; g < NUM_LINES; g++)
    begin : g_filt
        pfl_filter #(
            .LONG_N(LONG_N)
        ) u_filt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(s_reg.tick),
            .sample_i(s_reg.pin_sync[g]),
            .setting_i(pfl_filt_e'(s_reg.filter[2*g +: 2])),
            .level_o(level[g])
        );
    end

    // =====================================================================
    // Next-state logic
    always_comb
    begin
        logic [31:0] rd;
        logic [31:0] w;
        logic [3:0] nib;
        logic v;
        logic tv;
        rd = REG_RESET;
        w = REG_RESET;
        nib = 4'h0;
        v = 1'b0;
        tv = 1'b0;
        s_next = s_reg;

        // Current value of the addressed register
        case (wb_adr_i)
            OFS_MODE: rd = {16'h0000, s_reg.mode};
            OFS_STATIC_OUT: rd = {24'h00_0000, s_reg.static_out};
            OFS_STATIC_IN: rd = {24'h00_0000, level};
            OFS_DRIVE: rd = {16'h0000, s_reg.drive};
            OFS_FILTER: rd = {16'h0000, s_reg.filter};
            OFS_ROUTE0: rd = s_reg.route[31:0];
            OFS_ROUTE1: rd = s_reg.route[63:32];
            OFS_ROUTE2: rd = s_reg.route[95:64];
            OFS_DEST_POL: rd = {8'h00, s_reg.dest_pol};
            OFS_DEST_EDGE: rd = {8'h00, s_reg.dest_edge};
            OFS_EXPORT: rd = s_reg.export_sel;
            OFS_TBUS_ROUTE: rd = s_reg.tbus_route;
            default: rd = REG_RESET;                // Unmapped reads zero
        endcase

        // Bus: answer one cycle after the request, then drop
        s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        if (wb_cyc_i && wb_stb_i && !s_reg.ack)
        begin
            s_next.rdata = rd;
        end

        // Writes land on the edge at which the master sees ack
        if (wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack)
        begin
            w = merge(rd, wb_dat_i, wb_sel_i);
            case (wb_adr_i)
                OFS_MODE: s_next.mode = w[15:0];
                OFS_STATIC_OUT: s_next.static_out = w[7:0];
                OFS_DRIVE: s_next.drive = w[15:0];
                OFS_FILTER: s_next.filter = w[15:0];
                OFS_ROUTE0: s_next.route[31:0] = w;
                OFS_ROUTE1: s_next.route[63:32] = w;
                OFS_ROUTE2: s_next.route[95:64] = w;
                OFS_DEST_POL: s_next.dest_pol = w[23:0];
                OFS_DEST_EDGE: s_next.dest_edge = w[23:0];
                OFS_EXPORT: s_next.export_sel = w;
                OFS_TBUS_ROUTE: s_next.tbus_route = w;
                default: s_next.rdata = s_reg.rdata;        // Ignored
            endcase
        end

        // Two-flop synchronisers for pins and the trigger bus
        s_next.pin_meta = line_in_i;
        s_next.pin_sync = s_reg.pin_meta;
        s_next.tb_meta = tbus_in_i;
        s_next.tb_sync = s_reg.tb_meta;

        // Filter tick: 40 of every 50 clocks, never two misses in a row
        if (s_reg.phase + FILT_CLK_MHZ >= SYS_CLK_MHZ)
        begin
            s_next.phase = s_reg.phase + FILT_CLK_MHZ - SYS_CLK_MHZ;
        end
        else
        begin
            s_next.phase = s_reg.phase + FILT_CLK_MHZ;
        end
        // Tick flags the coming wrap, so reset gives one miss, not two
        s_next.tick = (s_next.phase + FILT_CLK_MHZ >= SYS_CLK_MHZ);

        // Destinations: enable nibble selects a timing-mode input
        for (int k = 0; k < NUM_DEST; k++)
        begin
            nib = s_reg.route[4*k +: 4];
            v = nib[NIB_EN_BIT] & s_reg.mode[nib[2:0]]
                & (level[nib[2:0]] ^ s_reg.dest_pol[k]);
            s_next.dest_prev[k] = v;
            s_next.dest[k] = s_reg.dest_edge[k] ?
                (v & ~s_reg.dest_prev[k]) : v;
        end

        // Trigger bus takes the raw synchronised pin, never the filter
        for (int b = 0; b < NUM_LINES; b++)
        begin
            nib = s_reg.tbus_route[4*b +: 4];
            s_next.tbus_oe[b] = nib[NIB_EN_BIT];
            s_next.tbus_out[b] = nib[NIB_EN_BIT]
                & s_reg.pin_sync[nib[2:0]];
        end

        // Output lines: drive state first, then static or timing value
        for (int x = 0; x < NUM_LINES; x++)
        begin
            tv = pick(src_i, s_reg.tb_sync[x], s_reg.export_sel[4*x +: 4]);
            v = s_reg.mode[MODE_OUT_LSB + x] ? tv
                : s_reg.static_out[x];
            unique case (pfl_drive_e'(s_reg.drive[2*x +: 2]))
                DRV_HIZ:
                begin
                    s_next.line_oe[x] = 1'b0;
                    s_next.line_out[x] = 1'b0;
                end
                DRV_LOW:
                begin
                    s_next.line_oe[x] = 1'b1;
                    s_next.line_out[x] = 1'b0;
                end
                DRV_HIGH:
                begin
                    s_next.line_oe[x] = 1'b1;
                    s_next.line_out[x] = 1'b1;
                end
                DRV_ACTIVE:
                begin
                    s_next.line_oe[x] = 1'b1;
                    s_next.line_out[x] = v;
                end
            endcase
        end
    end

    // Registers; reset leaves every line undriven and filters off
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // =====================================================================
    // Outputs, all from flops
    assign wb_dat_o = s_reg.rdata;
    assign wb_ack_o = s_reg.ack;
    assign line_out_o = s_reg.line_out;
    assign line_oe_o = s_reg.line_oe;
    assign tbus_out_o = s_reg.tbus_out;
    assign tbus_oe_o = s_reg.tbus_oe;
    assign dest_o = pfl_dest_s'(s_reg.dest);

    // =====================================================================
    // Checks
    logic [2:0] gap_cnt;

    // Counts consecutive clocks without a filter tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gap_cnt <= 3'h0;
        end
        else if (s_reg.tick)
        begin
            gap_cnt <= 3'h0;
        end
        else if (gap_cnt != 3'h7)
        begin
            gap_cnt <= gap_cnt + 3'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_reset_undriven: assert property (
        $fell(rst_i) |-> line_oe_o == 8'h00)
        else $error("output line driven right after reset");

    chk_tick_pattern: assert property (
        !s_reg.tick |=> s_reg.tick [*4] ##1 !s_reg.tick)
        else $error("filter tick rate is not four in five");

    chk_tick_gap: assert property (
        gap_cnt <= 3'(TICK_GAP_LIMIT))
        else $error("filter tick gap exceeds jitter bound");

    chk_drive_low: assert property (
        s_reg.drive[1:0] == DRV_LOW |=> line_oe_o[0] && !line_out_o[0])
        else $error("line 0 not driving low");

    chk_conv_inverted: assert property (
        (s_reg.drive[1:0] == DRV_ACTIVE && s_reg.mode[MODE_OUT_LSB]
         && s_reg.export_sel[3:0] == SRC_AI_CONVERT)
        |=> line_out_o[0] == !$past(src_i.ai_convert))
        else $error("convert clock not inverted on line 0");

    chk_static_out: assert property (
        (s_reg.drive[1:0] == DRV_ACTIVE && !s_reg.mode[MODE_OUT_LSB])
        |=> line_out_o[0] == $past(s_reg.static_out[0]))
        else $error("static output bit 0 not on line 0");

    chk_tbus_raw: assert property (
        s_reg.tbus_route[NIB_EN_BIT]
        |=> tbus_oe_o[0] && tbus_out_o[0] ==
            $past(s_reg.pin_sync[s_reg.tbus_route[2:0]]))
        else $error("trigger bus line 0 not fed unfiltered");

    chk_edge_pulse: assert property (
        (s_reg.dest[23] && $past(s_reg.dest_edge[23]))
        |-> s_reg.dest_prev[23] && !$past(s_reg.dest_prev[23]))
        else $error("edge destination pulsed without a new level");

    chk_filter_write: assert property (
        (wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack
         && wb_adr_i == OFS_FILTER && wb_sel_i == 4'hF)
        |=> s_reg.filter == $past(wb_dat_i[15:0]))
        else $error("filter setting write not taken");

    chk_static_in: assert property (
        (wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack
         && wb_adr_i == OFS_STATIC_IN)
        |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(level)})
        else $error("static input port read wrong");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

endmodule

// ===== testbench/pfl_line_partner.sv
// Board-side model: external sources on the inputs, loads on the outputs.
// Assumes the bench sets the source levels; idle pins rest on pull-downs.
`timescale 1ns/1ps
module pfl_line_partner
    import pfl_pkg::*;
(
    input wire logic [7:0] src_lvl_i,
    input wire logic [7:0] line_out_i,
    input wire logic [7:0] line_oe_i,
    output logic [7:0] line_in_o,
    output logic [7:0] pin_o
);
    // ====================================================================
    // Pins
    // An undriven pin reads 0 because the weak pull-down holds it there
    assign pin_o = line_oe_i & line_out_i;
    assign line_in_o = src_lvl_i;
endmodule

// ===== testbench/pfl_function_io_tb.sv
// Self-checking bench for the function line block over Wishbone.
// Assumes a 50 MHz clock and the long filter shortened to 20 samples.
`timescale 1ns/1ps
module pfl_function_io_tb;
    import pfl_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic wb_ack_o;
    logic [7:0] line_in_i, line_out_o, line_oe_o, tbus_out_o, tbus_oe_o;
    logic [7:0] src_lvl = 0, pin, tbus_in = 0;
    pfl_src_s src_i = '0;
    pfl_dest_s dest_o;
    int n_mismatch = 0, compares = 0;

    pfl_function_io #(.LONG_N(20)) pfl_function_io_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .line_in_i(line_in_i),
        .line_out_o(line_out_o), .line_oe_o(line_oe_o),
        .tbus_in_i(tbus_in), .tbus_out_o(tbus_out_o), .tbus_oe_o(tbus_oe_o),
        .src_i(src_i), .dest_o(dest_o));
    pfl_line_partner pfl_line_partner_inst (
        .src_lvl_i(src_lvl), .line_out_i(line_out_o),
        .line_oe_i(line_oe_o), .line_in_o(line_in_i), .pin_o(pin));

    // ====================================================================
    // Clock and watchdog
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    // About 170 cycles of tests; the margin covers slow answers
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end

    // ====================================================================
    // Tasks
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // One classic cycle; held until ack, released for one idle cycle
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        @(posedge clk_i);
        // Only the watchdog ends a wait for a missing ack
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input string nm);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    // ====================================================================
    // Tests
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("pin", 0, pin);
        rd(OFS_FILTER, 0, "filter");
        rd(OFS_DRIVE, 0, "drive");
        $display("test reset done");
        // Line 0 forced low, line 1 forced high, others follow port one
        wr(OFS_STATIC_OUT, 32'h0000_00a5);
        wr(OFS_DRIVE, 32'h0000_fff9);
        repeat (2) @(posedge clk_i);
        chk("pin", 32'h0000_00a6, pin);
        src_lvl <= 8'h3c;
        repeat (6) @(posedge clk_i);
        wr(OFS_STATIC_IN, 32'h0000_00ff);
        rd(OFS_STATIC_IN, 32'h0000_003c, "static_in");
        rd(8'h40, 0, "unmapped");
        $display("test static done");
        // Dest 0 from line 2, dest 23 from line 3
        wr(OFS_MODE, 32'h0000_ffff);
        wr(OFS_ROUTE0, 32'h0000_000a);
        wr(OFS_ROUTE2, 32'hb000_0000);
        repeat (3) @(posedge clk_i);
        chk("dest", 32'h0080_0001, dest_o);
        wr(OFS_DEST_POL, 32'h0000_0001);
        wr(OFS_DEST_EDGE, 32'h0080_0000);
        repeat (3) @(posedge clk_i);
        chk("dest", 0, dest_o);
        // Line 3 dips low; dest 23 pulses once when it returns
        src_lvl <= 8'h34;
        repeat (5) @(posedge clk_i);
        src_lvl <= 8'h3c;
        repeat (5) @(posedge clk_i);
        chk("pulse", 32'h0080_0000, dest_o);
        @(posedge clk_i);
        chk("pulse", 0, dest_o);
        $display("test routing done");
        // Lines 0,1,2 export convert, AO sample, AI start; rest give 0
        wr(OFS_DRIVE, 32'h0000_ffff);
        wr(OFS_EXPORT, 32'hffff_f450);
        repeat (2) @(posedge clk_i);
        chk("pin", 32'h0000_0003, pin);
        src_i.ai_convert <= 1;
        src_i.ao_sample <= 1;
        src_i.ai_start <= 1;
        repeat (2) @(posedge clk_i);
        chk("pin", 32'h0000_0004, pin);
        // Line 2 now repeats trigger bus input 2
        wr(OFS_EXPORT, 32'hffff_fe50);
        repeat (2) @(posedge clk_i);
        chk("pin", 0, pin);
        tbus_in <= 8'h04;
        repeat (5) @(posedge clk_i);
        chk("pin", 32'h0000_0004, pin);
        $display("test export done");
        // Line 3 short filter, line 4 long; bus line 0 from line 4
        // Let the old high levels drain before the filters start
        src_lvl <= 8'h00;
        repeat (4) @(posedge clk_i);
        wr(OFS_FILTER, 32'h0000_0340);
        wr(OFS_TBUS_ROUTE, 32'h0000_000c);
        src_lvl <= 8'h18;
        repeat (4) @(posedge clk_i);
        src_lvl <= 8'h00;
        repeat (12) @(posedge clk_i);
        rd(OFS_STATIC_IN, 0, "glitch");
        src_lvl <= 8'h18;
        repeat (4) @(posedge clk_i);
        chk("tbus", 1, tbus_out_o[0]);
        chk("tbus_oe", 1, tbus_oe_o);
        repeat (10) @(posedge clk_i);
        rd(OFS_STATIC_IN, 32'h0000_0008, "short");
        repeat (30) @(posedge clk_i);
        rd(OFS_STATIC_IN, 32'h0000_0018, "long");
        $display("test filter done");
        finish_test();
    end
endmodule
